// >>> rtl/prm_consts.vh
/*
  Constants for the pixel read-modify-write draw unit: widths, reset
  values, logic-unit operation codes and drawing direction codes.
  Assumes it is included by bare name from the rtl files of this unit.
*/
`ifndef PRM_CONSTS_VH
`define PRM_CONSTS_VH

// ----------------------------------------------------------------
// widths
// ----------------------------------------------------------------
`define PRM_WORD_W      16
`define PRM_DOT_W       4
`define PRM_ADDR_W      18
`define PRM_COUNT_W     14
`define PRM_OP_W        2
`define PRM_DIR_W       3

// ----------------------------------------------------------------
// memory cycle lengths in clock periods
// ----------------------------------------------------------------
`define PRM_RMW_CLKS    4
`define PRM_SHORT_CLKS  2

// ----------------------------------------------------------------
// logic unit operations
// ----------------------------------------------------------------
`define PRM_OP_REPLACE  2'h0
`define PRM_OP_COMPL    2'h1
`define PRM_OP_CLEAR    2'h2
`define PRM_OP_SET      2'h3

// ----------------------------------------------------------------
// directions, 0 straight down, counterclockwise to 7
// ----------------------------------------------------------------
`define PRM_DIR_DOWN    3'h0
`define PRM_DIR_DNRT    3'h1
`define PRM_DIR_RIGHT   3'h2
`define PRM_DIR_UPRT    3'h3
`define PRM_DIR_UP      3'h4
`define PRM_DIR_UPLT    3'h5
`define PRM_DIR_LEFT    3'h6
`define PRM_DIR_DNLT    3'h7

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define PRM_RST_MASK    16'h0001
`define PRM_RST_PATTERN 16'hFFFF
`define PRM_RST_PITCH   18'h00028

`endif

// >>> rtl/prm_draw_unit.v
/*
  Pixel read-modify-write datapath and address stepper of a display
  controller: four-clock read-modify-write cycles, two-clock display
  fetch and dynamic refresh cycles, pattern and mask registers, and the
  eight-direction word and dot pointer stepper.
  Assumes a synchronous display memory of 16-bit words on the same
  clock, and a command processor on the same clock driving the strobes.
*/
// Function
// - every drawing access is four clocks: address, read, modify, write back
// - all accesses use read-modify-write; only fetch and refresh take two
// - pattern loads from write-data command or parameter RAM during drawing
// - replace, complement, clear, set; mask-0 bits return as read
// - replace puts the pattern-derived modify bit into every enabled bit
// - others keep modify-0 bits; modify-1 inverts, sets or clears
// - graphics: one pattern bit per pixel; next bit and moved mask follow
// - character mode applies all pattern bits in parallel as modify word
// - cursor set decodes 4-bit dot position one-hot into the mask
// - a mask command loads any full 16-bit value into the mask
// - one pixel per cycle; next address computed during current cycle
// - memory is a linear array of 16-pixel words; dot selects pixel
// - direction is 3 bits, 0 straight down, rising counterclockwise to 7
// - vertical moves add or subtract the pitch from the word pointer
// - sideways moves rotate dot pointer; word pointer steps on wrap
// - all-ones mask steps the word pointer each cycle, whole word written
// - DMA moves whole words, diagonals change both row and column
// - arcs start in the given direction and curve; at most 45 degrees
// - line direction code is the octant holding the line's angle
// - pitch command gives memory width in words for vertical steps
// - draw count is cycles minus one; unit stops after count plus one
`timescale 1ns/1ps
`default_nettype none
`include "prm_consts.vh"

module prm_draw_unit
#(
  parameter WORD_W  = `PRM_WORD_W,
  parameter DOT_W   = `PRM_DOT_W,
  parameter ADDR_W  = `PRM_ADDR_W,
  parameter COUNT_W = `PRM_COUNT_W
)
(
  input  wire               MCLK_I,
  input  wire               RSTN_I,
  // command processor side
  input  wire               WRITE_DATA_CMD_I,
  input  wire [WORD_W-1:0]  WRITE_DATA_PATTERN_I,
  input  wire               PRAM_PATTERN_LOAD_I,
  input  wire [WORD_W-1:0]  PRAM_PATTERN_I,
  input  wire               MASK_CMD_I,
  input  wire [WORD_W-1:0]  MASK_VALUE_I,
  input  wire               CURSOR_SET_CMD_I,
  input  wire [ADDR_W-1:0]  CURSOR_WORD_I,
  input  wire [DOT_W-1:0]   CURSOR_DOT_I,
  input  wire               PITCH_CMD_I,
  input  wire [ADDR_W-1:0]  PITCH_I,
  input  wire [1:0]         OP_I,
  input  wire               CHAR_MODE_I,
  input  wire               DMA_MODE_I,
  input  wire [2:0]         DIR_I,
  input  wire [COUNT_W-1:0] DRAW_COUNT_I,
  input  wire               START_I,
  input  wire               FETCH_REQ_I,
  input  wire [ADDR_W-1:0]  FETCH_ADDR_I,
  input  wire               REFRESH_REQ_I,
  // display memory side
  input  wire [WORD_W-1:0]  MEM_RDATA_I,
  output reg  [ADDR_W-1:0]  MEM_ADDR_O,
  output reg                MEM_RD_O,
  output reg                MEM_WR_O,
  output reg  [WORD_W-1:0]  MEM_WDATA_O,
  output reg                MEM_RFSH_O,
  // status
  output reg                BUSY_O,
  output reg                SHORT_ACK_O,
  output reg                FETCH_VALID_O,
  output reg  [WORD_W-1:0]  FETCH_DATA_O,
  output reg  [ADDR_W-1:0]  EXEC_WORD_POINTER_O,
  output reg  [WORD_W-1:0]  MASK_O
);

  // ----------------------------------------------------------------
  // states
  // ----------------------------------------------------------------
  localparam [2:0] S_IDLE   = 3'h0;
  localparam [2:0] S_ADDR   = 3'h1;
  localparam [2:0] S_READ   = 3'h2;
  localparam [2:0] S_MOD    = 3'h3;
  localparam [2:0] S_WRITE  = 3'h4;
  localparam [2:0] S_SADDR  = 3'h5;
  localparam [2:0] S_SDATA  = 3'h6;

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function [WORD_W-1:0] one_hot;
    input [DOT_W-1:0] pos;
    begin
      one_hot = {{(WORD_W-1){1'b0}}, 1'b1} << pos;
    end
  endfunction

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  reg [2:0]         state;
  reg [WORD_W-1:0]  pattern;
  reg [DOT_W-1:0]   pattern_idx;
  reg [ADDR_W-1:0]  pitch;
  reg [COUNT_W-1:0] draw_count;
  reg [WORD_W-1:0]  read_data;
  reg               short_rfsh;

  wire [WORD_W-1:0] dot_position_pointer = MASK_O;
  wire [ADDR_W-1:0] exec_word_pointer    = EXEC_WORD_POINTER_O;

  // ----------------------------------------------------------------
  // modify data and logic unit
  // ----------------------------------------------------------------
  reg  [WORD_W-1:0] modify_word;
  wire [WORD_W-1:0] lu_result;

  always @*
  begin
    if (CHAR_MODE_I)
      modify_word = pattern;
    else
      modify_word = {WORD_W{pattern[pattern_idx]}};
  end

  prm_logic_unit
  #(
    .WORD_W   (WORD_W)
  )
  u_logic
  (
    .op_i     (OP_I),
    .read_i   (read_data),
    .modify_i (modify_word),
    .mask_i   (MASK_O),
    .result_o (lu_result)
  );

  // ----------------------------------------------------------------
  // next pixel address, worked out while the current cycle runs
  // ----------------------------------------------------------------
  reg              go_down;
  reg              go_up;
  reg              go_msb;
  reg              go_lsb;
  reg [ADDR_W-1:0] next_word;
  reg [WORD_W-1:0] next_mask;

  always @*
  begin
    // direction code: 0 down, counterclockwise; host picks the octant
    go_down = (DIR_I == `PRM_DIR_DNLT) || (DIR_I == `PRM_DIR_DOWN) ||
              (DIR_I == `PRM_DIR_DNRT);
    go_up   = (DIR_I == `PRM_DIR_UPRT) || (DIR_I == `PRM_DIR_UP) ||
              (DIR_I == `PRM_DIR_UPLT);
    go_msb  = (DIR_I == `PRM_DIR_DNRT) || (DIR_I == `PRM_DIR_RIGHT) ||
              (DIR_I == `PRM_DIR_UPRT);
    go_lsb  = (DIR_I == `PRM_DIR_UPLT) || (DIR_I == `PRM_DIR_LEFT) ||
              (DIR_I == `PRM_DIR_DNLT);
    next_word = exec_word_pointer;
    next_mask = dot_position_pointer;
    if (go_down)
      next_word = next_word + pitch;
    else if (go_up)
      next_word = next_word - pitch;
    if (DMA_MODE_I)
    begin
      // whole words: every sideways move changes the column as well
      if (go_msb)
        next_word = next_word + {{(ADDR_W-1){1'b0}}, 1'b1};
      else if (go_lsb)
        next_word = next_word - {{(ADDR_W-1){1'b0}}, 1'b1};
    end
    else if (go_msb)
    begin
      // an all-ones mask always has its top bit set, so it always steps
      if (dot_position_pointer[WORD_W-1])
        next_word = next_word + {{(ADDR_W-1){1'b0}}, 1'b1};
      next_mask = {MASK_O[WORD_W-2:0], MASK_O[WORD_W-1]};
    end
    else if (go_lsb)
    begin
      if (dot_position_pointer[0])
        next_word = next_word - {{(ADDR_W-1){1'b0}}, 1'b1};
      next_mask = {MASK_O[0], MASK_O[WORD_W-1:1]};
    end
  end

  // ----------------------------------------------------------------
  // cycle sequencer
  // ----------------------------------------------------------------
  wire short_req = REFRESH_REQ_I | FETCH_REQ_I;

  always @(posedge MCLK_I or negedge RSTN_I)
  begin
    if (!RSTN_I)
    begin
      state               <= S_IDLE;
      pattern             <= `PRM_RST_PATTERN;
      pattern_idx         <= {DOT_W{1'b0}};
      pitch               <= `PRM_RST_PITCH;
      draw_count          <= {COUNT_W{1'b0}};
      read_data           <= {WORD_W{1'b0}};
      short_rfsh          <= 1'b0;
      MEM_ADDR_O          <= {ADDR_W{1'b0}};
      MEM_RD_O            <= 1'b0;
      MEM_WR_O            <= 1'b0;
      MEM_WDATA_O         <= {WORD_W{1'b0}};
      MEM_RFSH_O          <= 1'b0;
      BUSY_O              <= 1'b0;
      SHORT_ACK_O         <= 1'b0;
      FETCH_VALID_O       <= 1'b0;
      FETCH_DATA_O        <= {WORD_W{1'b0}};
      EXEC_WORD_POINTER_O <= {ADDR_W{1'b0}};
      MASK_O              <= `PRM_RST_MASK;
    end
    else
    begin
      SHORT_ACK_O   <= 1'b0;
      FETCH_VALID_O <= 1'b0;
      // pattern may be refilled from parameter RAM mid-figure
      if (PRAM_PATTERN_LOAD_I)
        pattern <= PRAM_PATTERN_I;
      else if (WRITE_DATA_CMD_I && !BUSY_O)
        pattern <= WRITE_DATA_PATTERN_I;
      if (PITCH_CMD_I && !BUSY_O)
        pitch <= PITCH_I;
      if (!BUSY_O)
      begin
        if (MASK_CMD_I)
          MASK_O <= MASK_VALUE_I;
        else if (CURSOR_SET_CMD_I)
          MASK_O <= one_hot(CURSOR_DOT_I);
        if (CURSOR_SET_CMD_I)
          EXEC_WORD_POINTER_O <= CURSOR_WORD_I;
      end
      case (state)
        S_IDLE:
        begin
          if (short_req)
          begin
            state      <= S_SADDR;
            short_rfsh <= REFRESH_REQ_I;
            MEM_ADDR_O <= FETCH_ADDR_I;
            MEM_RD_O   <= ~REFRESH_REQ_I;
            MEM_RFSH_O <= REFRESH_REQ_I;
          end
          else if (START_I)
          begin
            // every access, single word or figure, is a full RMW
            state       <= S_ADDR;
            BUSY_O      <= 1'b1;
            draw_count  <= DRAW_COUNT_I;
            pattern_idx <= {DOT_W{1'b0}};
            MEM_ADDR_O  <= exec_word_pointer;
            MEM_RD_O    <= 1'b1;
          end
        end
        S_ADDR:
          state <= S_READ;
        S_READ:
        begin
          state     <= S_MOD;
          read_data <= MEM_RDATA_I;
          MEM_RD_O  <= 1'b0;
        end
        S_MOD:
        begin
          state               <= S_WRITE;
          MEM_WDATA_O         <= lu_result;
          MEM_WR_O            <= 1'b1;
          EXEC_WORD_POINTER_O <= next_word;
          MASK_O              <= next_mask;
          pattern_idx         <= pattern_idx + {{(DOT_W-1){1'b0}}, 1'b1};
          // index wraps naturally at the pattern width
        end
        S_WRITE:
        begin
          MEM_WR_O <= 1'b0;
          if (draw_count == {COUNT_W{1'b0}})
            BUSY_O <= 1'b0;
          else
            draw_count <= draw_count - {{(COUNT_W-1){1'b0}}, 1'b1};
          if (short_req)
          begin
            // short cycles slot in between read-modify-write cycles
            state      <= S_SADDR;
            short_rfsh <= REFRESH_REQ_I;
            MEM_ADDR_O <= FETCH_ADDR_I;
            MEM_RD_O   <= ~REFRESH_REQ_I;
            MEM_RFSH_O <= REFRESH_REQ_I;
          end
          else if (draw_count != {COUNT_W{1'b0}})
          begin
            state      <= S_ADDR;
            MEM_ADDR_O <= exec_word_pointer;
            MEM_RD_O   <= 1'b1;
          end
          else
            state <= S_IDLE;
        end
        S_SADDR:
        begin
          state       <= S_SDATA;
          SHORT_ACK_O <= 1'b1;
        end
        S_SDATA:
        begin
          MEM_RD_O   <= 1'b0;
          MEM_RFSH_O <= 1'b0;
          if (!short_rfsh)
          begin
            FETCH_DATA_O  <= MEM_RDATA_I;
            FETCH_VALID_O <= 1'b1;
          end
          if (BUSY_O)
          begin
            state      <= S_ADDR;
            MEM_ADDR_O <= exec_word_pointer;
            MEM_RD_O   <= 1'b1;
          end
          else
            state <= S_IDLE;
        end
        default:
          state <= S_IDLE;
      endcase
    end
  end

endmodule
`default_nettype wire

// >>> rtl/prm_logic_unit.v
/*
  Four-operation logic unit of the read-modify-write cycle.
  Assumes read data, modify data and mask are stable for the cycle in
  which the caller registers the result; purely combinational.
*/
`timescale 1ns/1ps
`default_nettype none
`include "prm_consts.vh"

module prm_logic_unit
#(
  parameter WORD_W = 16
)
(
  input  wire [1:0]        op_i,
  input  wire [WORD_W-1:0] read_i,
  input  wire [WORD_W-1:0] modify_i,
  input  wire [WORD_W-1:0] mask_i,
  output reg  [WORD_W-1:0] result_o
);

  reg [WORD_W-1:0] enabled;

  always @*
  begin
    // modify data only acts where the mask lets it
    enabled = modify_i & mask_i;
    case (op_i)
      `PRM_OP_REPLACE:
        // mask-0 bits come back as read, mask-1 bits take modify data
        result_o = (read_i & ~mask_i) | enabled;
      `PRM_OP_COMPL:
        result_o = read_i ^ enabled;
      `PRM_OP_CLEAR:
        result_o = read_i & ~enabled;
      `PRM_OP_SET:
        result_o = read_i | enabled;
      default:
        result_o = read_i;
    endcase
  end

endmodule
`default_nettype wire

// >>> verif/prm_draw_unit_sva.sv
/*
  Checker for the pixel read-modify-write draw unit, bound to its ports.
  Assumes one clock, active-low async reset, default widths.
*/
`timescale 1ns/1ps
`default_nettype none
module prm_draw_unit_sva
(
  input wire logic        MCLK_I,
  input wire logic        RSTN_I,
  input wire logic        MASK_CMD_I,
  input wire logic [15:0] MASK_VALUE_I,
  input wire logic        CURSOR_SET_CMD_I,
  input wire logic [17:0] CURSOR_WORD_I,
  input wire logic [3:0]  CURSOR_DOT_I,
  input wire logic        DMA_MODE_I,
  input wire logic [2:0]  DIR_I,
  input wire logic [15:0] MEM_RDATA_I,
  input wire logic [17:0] MEM_ADDR_O,
  input wire logic        MEM_RD_O,
  input wire logic        MEM_WR_O,
  input wire logic [15:0] MEM_WDATA_O,
  input wire logic        MEM_RFSH_O,
  input wire logic        BUSY_O,
  input wire logic        SHORT_ACK_O,
  input wire logic        FETCH_VALID_O,
  input wire logic [17:0] EXEC_WORD_POINTER_O,
  input wire logic [15:0] MASK_O
);
  // ----------------------------------------------------------------
  // sequences and properties
  // ----------------------------------------------------------------
  default clocking cb @(posedge MCLK_I);
  endclocking
  default disable iff (!RSTN_I);
  sequence rmw_s;
    MEM_RD_O ##1 MEM_RD_O ##1 !MEM_RD_O ##1 MEM_WR_O;
  endsequence
  sequence rfsh_s;
    MEM_RFSH_O && SHORT_ACK_O ##1 !MEM_RFSH_O;
  endsequence
  rmw_order_a: assert property ($rose(BUSY_O) |-> rmw_s)
    else $error("rmw cycle out of order");
  wr_same_addr_a: assert property (
    MEM_WR_O |-> MEM_ADDR_O == $past(MEM_ADDR_O, 3))
    else $error("write back to other address");
  wr_single_a: assert property (MEM_WR_O |=> !MEM_WR_O)
    else $error("write strobe too long");
  rfsh_len_a: assert property ($rose(MEM_RFSH_O) |=> rfsh_s)
    else $error("refresh cycle not two clocks");
  fetch_ack_a: assert property (
    $rose(FETCH_VALID_O) |-> $past(SHORT_ACK_O) && $past(MEM_RD_O)
      && !$past(MEM_RFSH_O))
    else $error("fetch data without ack");
  busy_end_a: assert property ($fell(BUSY_O) |-> $past(MEM_WR_O))
    else $error("busy fell outside write");
  mask_keep_a: assert property (
    MEM_WR_O |-> ((MEM_WDATA_O ^ $past(MEM_RDATA_I, 2))
      & ~$past(MASK_O)) == 16'h0000)
    else $error("unmasked bit changed");
  mask_load_a: assert property (
    MASK_CMD_I && !BUSY_O |=> MASK_O == $past(MASK_VALUE_I))
    else $error("mask command not loaded");
  cursor_load_a: assert property (
    CURSOR_SET_CMD_I && !MASK_CMD_I && !BUSY_O |=>
      MASK_O == (16'h0001 << $past(CURSOR_DOT_I))
      && EXEC_WORD_POINTER_O == $past(CURSOR_WORD_I))
    else $error("cursor dot not one-hot");
  rot_msb_a: assert property (
    MEM_WR_O && $past(DIR_I) == 3'h2 && !DMA_MODE_I && !$past(MASK_O[15])
      |-> MASK_O == {$past(MASK_O[14:0]), 1'b0}
      && EXEC_WORD_POINTER_O == $past(EXEC_WORD_POINTER_O))
    else $error("rotate toward msb wrong");
  whole_word_a: assert property (
    MEM_WR_O && $past(MASK_O) == 16'hFFFF && $past(DIR_I) == 3'h2
      |-> EXEC_WORD_POINTER_O == $past(EXEC_WORD_POINTER_O) + 18'h00001)
    else $error("whole word step missing");
endmodule
bind prm_draw_unit prm_draw_unit_sva u_sva
(
  .MCLK_I(MCLK_I), .RSTN_I(RSTN_I), .MASK_CMD_I(MASK_CMD_I),
  .MASK_VALUE_I(MASK_VALUE_I), .CURSOR_SET_CMD_I(CURSOR_SET_CMD_I),
  .CURSOR_WORD_I(CURSOR_WORD_I), .CURSOR_DOT_I(CURSOR_DOT_I),
  .DMA_MODE_I(DMA_MODE_I), .DIR_I(DIR_I), .MEM_RDATA_I(MEM_RDATA_I),
  .MEM_ADDR_O(MEM_ADDR_O), .MEM_RD_O(MEM_RD_O), .MEM_WR_O(MEM_WR_O),
  .MEM_WDATA_O(MEM_WDATA_O), .MEM_RFSH_O(MEM_RFSH_O), .BUSY_O(BUSY_O),
  .SHORT_ACK_O(SHORT_ACK_O), .FETCH_VALID_O(FETCH_VALID_O),
  .EXEC_WORD_POINTER_O(EXEC_WORD_POINTER_O), .MASK_O(MASK_O)
);
`default_nettype wire

// >>> verif/prm_mem_model.sv
/*
  Behavioural display memory of 16-bit words, registered read.
  Assumes the draw unit clock; only 256 words are modelled.
*/
`timescale 1ns/1ps
`default_nettype none
module prm_mem_model
(
  input  wire logic        clk_i,
  input  wire logic [17:0] addr_i,
  input  wire logic        rd_i,
  input  wire logic        wr_i,
  input  wire logic [15:0] wdata_i,
  output var  logic [15:0] rdata_o
);
  // ----------------------------------------------------------------
  // linear word array
  // ----------------------------------------------------------------
  logic [15:0] mem [0:255];
  initial rdata_o = 16'hA5A5;
  // when not read, data toggles so a late sample cannot pass by luck
  always @(posedge clk_i)
  begin
    if (wr_i)
      mem[addr_i[7:0]] <= wdata_i;
    rdata_o <= rd_i ? mem[addr_i[7:0]] : ~rdata_o;
  end
endmodule
`default_nettype wire

// >>> verif/tb_top.sv
/*
  Self-checking bench of the draw unit with a display memory model.
  Assumes the memory model answers one clock after the address.
*/
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic        clk, rstn, wd_c, pr_c, mk_c, cu_c, pi_c, ch, dma, st, fr;
  logic        rf, mrd, mwr, rfsh, busy, ack, fv;
  logic [15:0] wd_v, pr_v, mk_v, rdata, wdata, fdata, maskv, e;
  logic [17:0] cu_w, pi_v, fa, addr, ptr;
  logic [3:0]  cu_d;
  logic [1:0]  op;
  logic [2:0]  dir;
  logic [13:0] cnt;
  int          num_errors, cmp_count, i, k;

  prm_draw_unit u_prm_draw_unit
  (
    .MCLK_I(clk), .RSTN_I(rstn), .WRITE_DATA_CMD_I(wd_c),
    .WRITE_DATA_PATTERN_I(wd_v), .PRAM_PATTERN_LOAD_I(pr_c),
    .PRAM_PATTERN_I(pr_v), .MASK_CMD_I(mk_c), .MASK_VALUE_I(mk_v),
    .CURSOR_SET_CMD_I(cu_c), .CURSOR_WORD_I(cu_w), .CURSOR_DOT_I(cu_d),
    .PITCH_CMD_I(pi_c), .PITCH_I(pi_v), .OP_I(op), .CHAR_MODE_I(ch),
    .DMA_MODE_I(dma), .DIR_I(dir), .DRAW_COUNT_I(cnt), .START_I(st),
    .FETCH_REQ_I(fr), .FETCH_ADDR_I(fa), .REFRESH_REQ_I(rf),
    .MEM_RDATA_I(rdata), .MEM_ADDR_O(addr), .MEM_RD_O(mrd),
    .MEM_WR_O(mwr), .MEM_WDATA_O(wdata), .MEM_RFSH_O(rfsh),
    .BUSY_O(busy), .SHORT_ACK_O(ack), .FETCH_VALID_O(fv),
    .FETCH_DATA_O(fdata), .EXEC_WORD_POINTER_O(ptr), .MASK_O(maskv)
  );
  prm_mem_model u_prm_mem_model
  (
    .clk_i(clk), .addr_i(addr), .rd_i(mrd), .wr_i(mwr),
    .wdata_i(wdata), .rdata_o(rdata)
  );

  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  task step;
    @(posedge clk);
    #1;
  endtask
  task chk(input string nm, input logic [17:0] exp, input logic [17:0] got);
    cmp_count++;
    if (got !== exp)
    begin
      num_errors++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask
  // strobes {mask, cursor, pitch, write data, pram}; one idle clock after
  task cmd(input logic [4:0] s, input logic [17:0] a, input logic [15:0] v);
    cu_w = a;
    cu_d = v[3:0];
    pi_v = a;
    {mk_v, wd_v, pr_v} = {v, v, v};
    {mk_c, cu_c, pi_c, wd_c, pr_c} = s;
    step;
    {mk_c, cu_c, pi_c, wd_c, pr_c} = 5'h00;
    step;
  endtask
  // poke tries a mask load while busy, which must be ignored
  task draw(input logic [1:0] o, input logic c, d, input logic [2:0] r,
            input logic [13:0] n, input logic poke);
    {op, ch, dma, dir, cnt} = {o, c, d, r, n};
    st = 1'b1;
    step;
    st = 1'b0;
    mk_v = 16'h1234;
    mk_c = poke;
    step;
    mk_c = 1'b0;
    for (i = 0; i < 100 && busy !== 1'b0; i++)
      step;
    chk("busy", 18'h0, busy);
    step;
  endtask
  task end_of_test;
    if (num_errors == 0 && cmp_count > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  // ----------------------------------------------------------------
  // clock, watchdog, tests
  // ----------------------------------------------------------------
  initial
  begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  initial
  begin
    #1000000;
    num_errors++;
    end_of_test;
  end
  initial
  begin
    {wd_c, pr_c, mk_c, cu_c, pi_c, ch, dma, st, fr, rf} = '0;
    {wd_v, pr_v, mk_v, cu_w, pi_v, fa, cu_d, op, dir, cnt} = '0;
    {num_errors, cmp_count} = '0;
    rstn = 1'b0;
    repeat (5) @(posedge clk);
    #1 rstn = 1'b1;
    chk("mask", 18'h00001, maskv);
    chk("ptr", 18'h0, ptr);
    cmd(5'h04, 18'h00003, 16'h0000);
    cmd(5'h02, 18'h0, 16'h3C5A);
    for (k = 0; k < 4; k++)
    begin
      u_prm_mem_model.mem[20] = 16'h5A3C;
      cmd(5'h08, 18'h00014, 16'h0000);
      cmd(5'h10, 18'h0, 16'h0FF0);
      draw(k, 1'b1, 1'b0, 3'h4, 14'h0, 1'b0);
      e = k == 0 ? 16'h3C5A : k == 1 ? 16'h5A3C ^ 16'h3C5A :
          k == 2 ? 16'h5A3C & ~16'h3C5A : 16'h5A3C | 16'h3C5A;
      e = (16'h5A3C & ~16'h0FF0) | (e & 16'h0FF0);
      chk("op word", e, u_prm_mem_model.mem[20]);
      chk("up step", 18'h00011, ptr);
    end
    u_prm_mem_model.mem[10] = 16'h0000;
    cmd(5'h02, 18'h0, 16'hFFFE);
    cmd(5'h08, 18'h0000A, 16'h0000);
    draw(2'h3, 1'b0, 1'b0, 3'h2, 14'h1, 1'b0);
    chk("pixel", 18'h00002, u_prm_mem_model.mem[10]);
    chk("dot", 18'h00004, maskv);
    chk("ptr", 18'h0000A, ptr);
    cmd(5'h08, 18'h0001E, 16'h000F);
    draw(2'h0, 1'b0, 1'b0, 3'h2, 14'h0, 1'b1);
    chk("msb wrap", 18'h0001F, ptr);
    chk("busy mask", 18'h00001, maskv);
    cmd(5'h08, 18'h0001E, 16'h0000);
    draw(2'h0, 1'b0, 1'b0, 3'h6, 14'h0, 1'b0);
    chk("lsb wrap", 18'h0001D, ptr);
    chk("lsb dot", 18'h08000, maskv);
    for (k = 40; k < 58; k++)
      u_prm_mem_model.mem[k] = 16'hA5A5;
    cmd(5'h01, 18'h0, 16'h0005);
    cmd(5'h08, 18'h00028, 16'h0000);
    cmd(5'h10, 18'h0, 16'hFFFF);
    draw(2'h0, 1'b0, 1'b0, 3'h2, 14'h0010, 1'b0);
    chk("word 0", 18'h0FFFF, u_prm_mem_model.mem[40]);
    chk("word 1", 18'h00000, u_prm_mem_model.mem[41]);
    chk("word 2", 18'h0FFFF, u_prm_mem_model.mem[42]);
    chk("word 16", 18'h0FFFF, u_prm_mem_model.mem[56]);
    chk("word 17", 18'h0A5A5, u_prm_mem_model.mem[57]);
    chk("ptr", 18'h00039, ptr);
    cmd(5'h08, 18'h00032, 16'h0000);
    draw(2'h0, 1'b0, 1'b1, 3'h1, 14'h0, 1'b0);
    chk("dma ptr", 18'h00036, ptr);
    chk("dma mask", 18'h00001, maskv);
    u_prm_mem_model.mem[60] = 16'hC3A5;
    fa = 18'h0003C;
    fr = 1'b1;
    for (i = 0; i < 10 && ack !== 1'b1; i++)
      step;
    fr = 1'b0;
    step;
    chk("fetch valid", 18'h1, fv);
    chk("fetch data", 18'h0C3A5, fdata);
    rf = 1'b1;
    for (i = 0; i < 10 && ack !== 1'b1; i++)
      step;
    chk("refresh", 18'h1, rfsh);
    rf = 1'b0;
    step;
    step;
    end_of_test;
  end
endmodule
`default_nettype wire
